// [logic/servo_gain_set_selector.sv]
// Functional notes
// - feedback source from select, loaded at restart
// - encoder speed is differenced position samples
// - observer always runs, estimate output for monitoring
// - encoder speed low-passed by live filter time
// - observer correction scaled by live observer gain
// - two gain groups, selector picks driving group
// - first group unless mode condition met
// - mode 0 fixes first, mode 9 second
// - mode 1 follows external gain select input
// - mode 10 follows positioning completed flag
// - modes 2-4: torque, deviation, acceleration thresholds
// - modes 5-7: speed ref, position ref, speed
// - modes 2-7 second group above threshold
// - hysteresis band around threshold stops chatter
// - mode 8 position met above threshold plus hysteresis
// - mode 8 also needs speed above threshold
// - mode change waits for restart
// - delay, thresholds, ramp, hysteresis apply live
// - position gain ramps over ramp time
`default_nettype none
module servo_gain_set_selector #(
  parameter int DELAY_TICK_CYCLES = gain_sel_pkg::DELAY_TICK_CYCLES
) (
  input  wire logic               REF_CLK,                   // clock
  input  wire logic               RESET,                     // sync, high
  input  wire logic               RESTART,                   // load settings
  input  wire logic               FEEDBACK_SOURCE_SELECT,    // 0 enc 1 obs
  input  wire logic [3:0]         GAIN_SWITCH_MODE,          // mode code
  input  wire logic [31:0]        ENCODER_POSITION,          // position
  input  wire logic               ENCODER_VALID,             // sample pulse
  input  wire logic [15:0]        ENCODER_SPEED_FILTER_TIME, // 0.01 ms
  input  wire logic [15:0]        OBSERVER_GAIN,             // observer gain
  input  wire logic               GAIN_SELECT_IN,            // ext pin
  input  wire logic               POSITIONING_DONE,          // flag
  input  wire logic signed [15:0] TORQUE_REF,                // torque ref
  input  wire logic signed [15:0] DEVIATION,                 // pos deviation
  input  wire logic signed [15:0] ACCELERATION,              // acceleration
  input  wire logic signed [15:0] SPEED_REF,                 // speed ref
  input  wire logic signed [15:0] POSITION_REF,              // position ref
  input  wire logic [15:0]        TORQUE_THRESHOLD,          // mode 2
  input  wire logic [15:0]        DEVIATION_THRESHOLD,       // mode 3
  input  wire logic [15:0]        ACCELERATION_THRESHOLD,    // mode 4
  input  wire logic [15:0]        SPEED_REFERENCE_THRESHOLD, // mode 5
  input  wire logic [15:0]        POSITION_SWITCH_THRESHOLD, // modes 6, 8
  input  wire logic [15:0]        ACTUAL_SPEED_THRESHOLD,    // modes 7, 8
  input  wire logic [15:0]        SWITCH_HYSTERESIS,         // band
  input  wire logic [15:0]        SWITCH_DELAY_TIME,         // 0.1 ms
  input  wire logic [15:0]        POSITION_GAIN_RAMP_TIME,   // 0.1 ms
  input  wire logic [15:0]        SPEED_GAIN_FIRST,          // group 1
  input  wire logic [15:0]        SPEED_GAIN_SECOND,         // group 2
  input  wire logic [15:0]        INTEGRAL_TIME_FIRST,       // group 1
  input  wire logic [15:0]        INTEGRAL_TIME_SECOND,      // group 2
  input  wire logic [15:0]        POSITION_GAIN_FIRST,       // group 1
  input  wire logic [15:0]        POSITION_GAIN_SECOND,      // group 2
  input  wire logic [15:0]        TORQUE_FILTER_TIME_FIRST,  // group 1
  input  wire logic [15:0]        TORQUE_FILTER_TIME_SECOND, // group 2
  output logic signed [15:0]      SPEED_FEEDBACK,            // loop feedback
  output logic signed [15:0]      ENCODER_SPEED,             // filtered enc
  output logic signed [15:0]      OBSERVED_SPEED,            // observer
  output logic                    SECOND_GROUP_ACTIVE,       // group sel
  output logic                    GAIN_RAMPING,              // ramp running
  output logic [15:0]             SPEED_GAIN,                // active
  output logic [15:0]             INTEGRAL_TIME,             // active
  output logic [15:0]             POSITION_GAIN,             // ramped
  output logic [15:0]             TORQUE_FILTER_TIME         // active
);
  default clocking dflt_cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // magnitude of a signed quantity, saturating at the top
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    logic [15:0] r;
    r = v[15] ? 16'(-v) : 16'(v);
    if (v == 16'sh8000) r = 16'h7FFF;
    return r;
  endfunction : mag16

  // ---------------- input sync and time bases ----------------
  logic        gsel_meta_reg, gsel_sync_reg;   // pin synchroniser
  logic [15:0] dtick_cnt_reg, dtick_cnt_next;  // 0.1 ms divider
  logic [15:0] ftick_cnt_reg, ftick_cnt_next;  // 0.01 ms divider
  logic        delay_tick;                     // 0.1 ms enable
  logic        filter_tick;                    // 0.01 ms enable

  // free running dividers give one-cycle enables
  always_comb begin
    delay_tick     = (dtick_cnt_reg == 16'(DELAY_TICK_CYCLES - 1));
    filter_tick    = (ftick_cnt_reg ==
                      16'(gain_sel_pkg::FILTER_TICK_CYCLES - 1));
    dtick_cnt_next = delay_tick ? 16'h0000 : dtick_cnt_reg + 16'h0001;
    ftick_cnt_next = filter_tick ? 16'h0000 : ftick_cnt_reg + 16'h0001;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      gsel_meta_reg <= 1'h0;
      gsel_sync_reg <= 1'h0;
      dtick_cnt_reg <= 16'h0000;
      ftick_cnt_reg <= 16'h0000;
    end else begin
      gsel_meta_reg <= GAIN_SELECT_IN;
      gsel_sync_reg <= gsel_meta_reg;
      dtick_cnt_reg <= dtick_cnt_next;
      ftick_cnt_reg <= ftick_cnt_next;
    end
  end

  // ---------------- restart-only settings ----------------
  logic                    fb_sel_reg, fb_sel_next;     // feedback source
  gain_sel_pkg::gain_mode_t mode_reg, mode_next;        // switch mode

  // only a restart loads them; live changes are ignored until then
  always_comb begin
    fb_sel_next = fb_sel_reg;
    mode_next   = mode_reg;
    if (RESTART) begin
      fb_sel_next = FEEDBACK_SOURCE_SELECT;
      mode_next   = gain_sel_pkg::gain_mode_t'(GAIN_SWITCH_MODE);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      fb_sel_reg <= gain_sel_pkg::FB_RESET;
      mode_reg   <= gain_sel_pkg::MODE_RESET;
    end else begin
      fb_sel_reg <= fb_sel_next;
      mode_reg   <= mode_next;
    end
  end

  a_mode_restart: assert property (!RESTART |=> $stable(mode_reg))
    else $error("gain switch mode changed without restart");
  a_fb_restart: assert property (!RESTART |=> $stable(fb_sel_reg))
    else $error("feedback source changed without restart");

  // ---------------- speed path ----------------
  logic [31:0]        prev_pos_reg, prev_pos_next; // last sample
  logic signed [15:0] raw_spd_reg, raw_spd_next;   // differenced speed
  logic signed [15:0] obs_reg, obs_next;           // observer estimate
  logic signed [15:0] fb_reg, fb_next;             // selected feedback
  logic signed [15:0] lpf_spd;                     // filtered encoder
  logic signed [16:0] obs_err;                     // estimate error
  logic signed [33:0] obs_corr;                    // scaled correction
  logic signed [17:0] obs_sum;                     // widened update
  logic [31:0]        pos_delta;                   // position change

  // differencing at a fixed sample rate is speed in counts per sample
  always_comb begin
    pos_delta     = ENCODER_POSITION - prev_pos_reg;
    prev_pos_next = prev_pos_reg;
    raw_spd_next  = raw_spd_reg;
    obs_next      = obs_reg;
    obs_err       = 17'(raw_spd_reg) - 17'(obs_reg);
    obs_corr      = (34'(obs_err) * $signed({18'h0, OBSERVER_GAIN}))
                    >>> gain_sel_pkg::OBS_SHIFT;
    obs_sum       = 18'(obs_reg) + 18'(obs_corr);
    if (ENCODER_VALID) begin
      prev_pos_next = ENCODER_POSITION;
      raw_spd_next  = 16'(pos_delta);
      obs_next      = obs_sum[15:0];
    end
    // large gains track closer but can overshoot; no clamping here
    fb_next = (fb_sel_reg == gain_sel_pkg::FB_OBSERVER) ? obs_reg
                                                        : lpf_spd;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      prev_pos_reg <= 32'h00000000;
      raw_spd_reg  <= 16'h0000;
      obs_reg      <= 16'h0000;
      fb_reg       <= 16'h0000;
    end else begin
      prev_pos_reg <= prev_pos_next;
      raw_spd_reg  <= raw_spd_next;
      obs_reg      <= obs_next;
      fb_reg       <= fb_next;
    end
  end

  // encoder speed smoothing, filter time read live
  speed_lpf enc_filter (
    .clk        (REF_CLK),
    .rst        (RESET),
    .tick       (filter_tick),
    .din        (raw_spd_reg),
    .time_const (ENCODER_SPEED_FILTER_TIME),
    .dout       (lpf_spd)
  );

  assign SPEED_FEEDBACK = fb_reg;
  assign ENCODER_SPEED  = lpf_spd;
  assign OBSERVED_SPEED = obs_reg;

  a_fb_observer: assert property (fb_sel_reg && $stable(fb_sel_reg)
    |=> SPEED_FEEDBACK == $past(obs_reg))
    else $error("observer feedback not routed");
  a_fb_encoder: assert property (!fb_sel_reg && $stable(fb_sel_reg)
    |=> SPEED_FEEDBACK == $past(lpf_spd))
    else $error("filtered encoder feedback not routed");
  a_obs_tracks: assert property (!ENCODER_VALID |=> $stable(obs_reg))
    else $error("observer moved without a sample");

  // ---------------- switching condition ----------------
  logic        cond_reg, cond_next;     // hysteresis comparator state
  logic [15:0] qty;                     // monitored magnitude
  logic [15:0] thr;                     // its threshold
  logic [16:0] thr_hi;                  // switch-on level
  logic [16:0] thr_lo;                  // switch-off level
  logic        spd_over;                // speed above speed threshold
  logic        want;                    // group the mode asks for

  // on above threshold plus band, off at or below threshold minus band
  always_comb begin
    case (mode_reg)
      gain_sel_pkg::MODE_TORQUE:    thr = TORQUE_THRESHOLD;
      gain_sel_pkg::MODE_DEVIATION: thr = DEVIATION_THRESHOLD;
      gain_sel_pkg::MODE_ACCEL:     thr = ACCELERATION_THRESHOLD;
      gain_sel_pkg::MODE_SPEED_REF: thr = SPEED_REFERENCE_THRESHOLD;
      gain_sel_pkg::MODE_ACT_SPEED: thr = ACTUAL_SPEED_THRESHOLD;
      default:                      thr = POSITION_SWITCH_THRESHOLD;
    endcase
    case (mode_reg)
      gain_sel_pkg::MODE_TORQUE:    qty = mag16(TORQUE_REF);
      gain_sel_pkg::MODE_DEVIATION: qty = mag16(DEVIATION);
      gain_sel_pkg::MODE_ACCEL:     qty = mag16(ACCELERATION);
      gain_sel_pkg::MODE_SPEED_REF: qty = mag16(SPEED_REF);
      gain_sel_pkg::MODE_ACT_SPEED: qty = mag16(fb_reg);
      default:                      qty = mag16(POSITION_REF);
    endcase
    thr_hi = {1'h0, thr} + {1'h0, SWITCH_HYSTERESIS};
    thr_lo = (thr > SWITCH_HYSTERESIS) ?
             {1'h0, thr - SWITCH_HYSTERESIS} : 17'h00000;
    if (mode_reg < gain_sel_pkg::MODE_TORQUE ||
        mode_reg > gain_sel_pkg::MODE_POS_AND_SPD) begin
      cond_next = 1'h0;
    end else if (cond_reg) begin
      cond_next = ({1'h0, qty} > thr_lo);
    end else begin
      cond_next = ({1'h0, qty} > thr_hi);
    end
    spd_over = (mag16(fb_reg) > ACTUAL_SPEED_THRESHOLD);
    case (mode_reg)
      gain_sel_pkg::MODE_FIXED_FIRST:  want = 1'h0;
      gain_sel_pkg::MODE_FIXED_SECOND: want = 1'h1;
      gain_sel_pkg::MODE_EXT_INPUT:    want = gsel_sync_reg;
      gain_sel_pkg::MODE_POS_DONE:     want = POSITIONING_DONE;
      gain_sel_pkg::MODE_POS_AND_SPD:  want = cond_reg && spd_over;
      gain_sel_pkg::MODE_TORQUE, gain_sel_pkg::MODE_DEVIATION,
      gain_sel_pkg::MODE_ACCEL, gain_sel_pkg::MODE_SPEED_REF,
      gain_sel_pkg::MODE_POS_REF,
      gain_sel_pkg::MODE_ACT_SPEED:    want = cond_reg;
      default:                         want = 1'h0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cond_reg <= 1'h0;
    end else begin
      cond_reg <= cond_next;
    end
  end

  a_hyst_rise: assert property ($rose(cond_reg)
    |-> $past({1'h0, qty} > thr_hi))
    else $error("condition set below threshold plus hysteresis");
  // watch the group output, not the request, so broken decoding shows
  a_mode8_both: assert property (mode_reg == gain_sel_pkg::MODE_POS_AND_SPD
    && !(cond_reg && spd_over) && !group_reg |=> !group_reg)
    else $error("mode 8 second group without both conditions");
  a_ext_follow: assert property (mode_reg == gain_sel_pkg::MODE_EXT_INPUT
    && !gsel_sync_reg && !group_reg |=> !group_reg)
    else $error("external select not followed");
  a_done_follow: assert property (mode_reg == gain_sel_pkg::MODE_POS_DONE
    && !POSITIONING_DONE && !group_reg |=> !group_reg)
    else $error("positioning flag not followed");

  // ---------------- group selection with delay ----------------
  logic        group_reg, group_next;   // 1 = second group active
  logic [15:0] dly_cnt_reg, dly_cnt_next; // delay ticks elapsed

  // a new request must hold for the delay; any bounce restarts it
  always_comb begin
    group_next   = group_reg;
    dly_cnt_next = dly_cnt_reg;
    if (want == group_reg) begin
      dly_cnt_next = 16'h0000;
    end else if (dly_cnt_reg >= SWITCH_DELAY_TIME) begin
      group_next   = want;
      dly_cnt_next = 16'h0000;
    end else if (delay_tick) begin
      dly_cnt_next = dly_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      group_reg   <= 1'h0;
      dly_cnt_reg <= 16'h0000;
    end else begin
      group_reg   <= group_next;
      dly_cnt_reg <= dly_cnt_next;
    end
  end

  a_delay_met: assert property ($changed(group_reg)
    |-> $past(dly_cnt_reg >= SWITCH_DELAY_TIME))
    else $error("group switched before delay elapsed");
  a_mode0_first: assert property (mode_reg == gain_sel_pkg::MODE_FIXED_FIRST
    && !group_reg |=> !group_reg)
    else $error("mode 0 left the first group");
  c_switch_second: cover property ($rose(group_reg));
  c_mode8_second: cover property (mode_reg ==
    gain_sel_pkg::MODE_POS_AND_SPD && $rose(group_reg));
  c_observer_fb: cover property (fb_sel_reg && ENCODER_VALID);

  // ---------------- gain outputs and position gain ramp ----------------
  logic        ramp_reg, ramp_next;           // ramp in progress
  logic [15:0] ramp_from_reg, ramp_from_next; // gain at switch
  logic [15:0] elapsed_reg, elapsed_next;     // ramp ticks elapsed
  logic [15:0] pgain_reg, pgain_next;         // position gain out
  logic [15:0] pgain_target;                  // active group value
  logic [15:0] sgain_reg, sgain_next;         // speed gain out
  logic [15:0] itime_reg, itime_next;         // integral time out
  logic [15:0] tfilt_reg, tfilt_next;         // torque filter out
  logic signed [16:0] ramp_diff;              // target minus start
  logic signed [33:0] ramp_frac;              // interpolated offset

  // other gains step at once; position gain glides to avoid a jolt
  always_comb begin
    pgain_target = group_reg ? POSITION_GAIN_SECOND : POSITION_GAIN_FIRST;
    sgain_next   = group_reg ? SPEED_GAIN_SECOND : SPEED_GAIN_FIRST;
    itime_next   = group_reg ? INTEGRAL_TIME_SECOND : INTEGRAL_TIME_FIRST;
    tfilt_next   = group_reg ? TORQUE_FILTER_TIME_SECOND
                             : TORQUE_FILTER_TIME_FIRST;
    ramp_diff    = $signed({1'h0, pgain_target}) -
                   $signed({1'h0, ramp_from_reg});
    ramp_frac    = (POSITION_GAIN_RAMP_TIME == 16'h0000) ? 34'sh0 :
                   (34'(ramp_diff) * $signed({18'h0, elapsed_reg})) /
                   $signed({18'h0, POSITION_GAIN_RAMP_TIME});
    ramp_next      = ramp_reg;
    ramp_from_next = ramp_from_reg;
    elapsed_next   = elapsed_reg;
    if (ramp_reg) begin
      pgain_next = 16'(34'(ramp_from_reg) + ramp_frac);
      if (elapsed_reg >= POSITION_GAIN_RAMP_TIME) begin
        ramp_next = 1'h0;
      end else if (delay_tick) begin
        elapsed_next = elapsed_reg + 16'h0001;
      end
    end else begin
      pgain_next = pgain_target;
    end
    if (group_next != group_reg) begin
      ramp_next      = (POSITION_GAIN_RAMP_TIME != 16'h0000);
      ramp_from_next = pgain_reg;
      elapsed_next   = 16'h0000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ramp_reg      <= 1'h0;
      ramp_from_reg <= 16'h0000;
      elapsed_reg   <= 16'h0000;
      pgain_reg     <= 16'h0000;
      sgain_reg     <= 16'h0000;
      itime_reg     <= 16'h0000;
      tfilt_reg     <= 16'h0000;
    end else begin
      ramp_reg      <= ramp_next;
      ramp_from_reg <= ramp_from_next;
      elapsed_reg   <= elapsed_next;
      pgain_reg     <= pgain_next;
      sgain_reg     <= sgain_next;
      itime_reg     <= itime_next;
      tfilt_reg     <= tfilt_next;
    end
  end

  assign SECOND_GROUP_ACTIVE = group_reg;
  assign GAIN_RAMPING        = ramp_reg;
  assign POSITION_GAIN       = pgain_reg;
  assign SPEED_GAIN          = sgain_reg;
  assign INTEGRAL_TIME       = itime_reg;
  assign TORQUE_FILTER_TIME  = tfilt_reg;

  a_ramp_settled: assert property (!ramp_reg && !$changed(group_reg)
    |=> POSITION_GAIN == $past(pgain_target))
    else $error("position gain off target outside ramp");
  a_group_gains: assert property (group_reg && $stable(group_reg)
    |=> SPEED_GAIN == $past(SPEED_GAIN_SECOND))
    else $error("speed gain not from second group");
endmodule : servo_gain_set_selector
`default_nettype wire

// [common/gain_sel_pkg.sv]
`default_nettype none
package gain_sel_pkg;
  // data widths of the loop quantities and settings
  localparam int SPD_W = 16;        // speeds and compared quantities
  localparam int PAR_W = 16;        // setting words
  localparam int POS_W = 32;        // encoder position counts

  // feedback source select codes
  localparam logic FB_ENCODER  = 1'h0; // differentiated encoder speed
  localparam logic FB_OBSERVER = 1'h1; // observer estimate
  localparam logic FB_RESET    = FB_ENCODER;

  // gain switch mode codes
  typedef enum logic [3:0] {
    MODE_FIXED_FIRST  = 4'h0,
    MODE_EXT_INPUT    = 4'h1,
    MODE_TORQUE       = 4'h2,
    MODE_DEVIATION    = 4'h3,
    MODE_ACCEL        = 4'h4,
    MODE_SPEED_REF    = 4'h5,
    MODE_POS_REF      = 4'h6,
    MODE_ACT_SPEED    = 4'h7,
    MODE_POS_AND_SPD  = 4'h8,
    MODE_FIXED_SECOND = 4'h9,
    MODE_POS_DONE     = 4'hA
  } gain_mode_t;
  localparam gain_mode_t MODE_RESET = MODE_FIXED_FIRST;

  // time bases: delay and ramp settings count 0.1 ms, filter 0.01 ms
  localparam int CLK_MHZ             = 100;  // REF_CLK rate
  localparam int DELAY_UNIT_US_X10   = 1000; // 0.1 ms in tenths of a us
  localparam int FILTER_UNIT_US_X10  = 100;  // 0.01 ms in tenths of a us
  localparam int DELAY_TICK_CYCLES   = DELAY_UNIT_US_X10 * CLK_MHZ / 10;
  localparam int FILTER_TICK_CYCLES  = FILTER_UNIT_US_X10 * CLK_MHZ / 10;

  // observer correction scaling: gain setting / 2**OBS_SHIFT per sample
  localparam int OBS_SHIFT = 10;
endpackage : gain_sel_pkg
`default_nettype wire

// [logic/speed_lpf.sv]
`default_nettype none
// first order low-pass, one update per filter tick
module speed_lpf (
  input  wire logic                     clk,        // control clock
  input  wire logic                     rst,        // sync reset, high
  input  wire logic                     tick,       // 0.01 ms enable
  input  wire logic signed [15:0]       din,        // raw speed
  input  wire logic        [15:0]       time_const, // filter time setting
  output logic signed      [15:0]       dout        // smoothed speed
);
  logic signed [15:0] y_reg;   // filter state
  logic signed [15:0] y_next;  // next state
  logic signed [16:0] diff;    // input minus state
  logic signed [17:0] divisor; // time constant plus one tick
  logic signed [17:0] step;    // correction this tick
  logic signed [17:0] sum;     // widened new state

  // larger time constant: smaller step, smoother but more lag
  always_comb begin
    diff    = 17'(din) - 17'(y_reg);
    divisor = $signed({2'h0, time_const}) + 18'sh00001;
    step    = 18'(diff) / divisor;
    sum     = 18'(y_reg) + step;
    y_next  = tick ? sum[15:0] : y_reg;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      y_reg <= 16'h0000;
    end else begin
      y_reg <= y_next;
    end
  end

  assign dout = y_reg;
endmodule : speed_lpf
`default_nettype wire

// [verification/motor_feedback_model.sv]
`default_nettype none
// encoder stand-in: steady velocity, one sample every 8 clocks
module motor_feedback_model (
  input  wire logic        clk, // control clock
  input  wire logic        rst, // sync reset, high
  input  wire logic [15:0] vel, // counts per sample
  output logic      [31:0] pos, // encoder position
  output logic             vld  // sample pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_reg; // sample divider
  // position moves only on the sample edge so it is stable when taken
  always_ff @(posedge clk) begin
    div_reg <= rst ? 3'h0 : div_reg + 3'h1;
    vld     <= !rst && div_reg == 3'h7;
    if (rst) pos <= 32'h0;
    else if (div_reg == 3'h7) pos <= pos + {{16{vel[15]}}, vel};
  end
endmodule : motor_feedback_model
`default_nettype wire

// [verification/servo_gain_set_selector_tb.sv]
`default_nettype none
module servo_gain_set_selector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, rs = 1'b0, fb = 1'b0; // clock, reset, restart
  logic gsel = 1'b0, done = 1'b0; // external select, positioning flag
  logic signed [15:0] enc, obs; // encoder and observer speeds
  logic rmp; // ramp running
  logic [3:0] mode = 4'h0; // mode pin
  logic [15:0] thr = 16'h0064, hys = 16'h0002, dly = 16'h0003; // settings
  logic [15:0] ramp = 16'h0004, ftim = 16'h0000; // ramp, filter time
  logic [15:0] ogain = 16'h0400, vel = 16'h0000; // observer gain, velocity
  logic signed [15:0] mag = 16'sh0000, fbk; // compared value, feedback
  logic [15:0] g1[4], g2[4], sg, it, pg, tf; // gain groups, active gains
  logic [31:0] pos; // encoder position
  logic grp, vld; // group select, sample pulse
  int seed = 13113, fail_count = 0, checked = 0;
  always #5 clk = ~clk;
  motor_feedback_model u_motor_feedback_model (.clk(clk), .rst(rst),
    .vel(vel), .pos(pos), .vld(vld));
  servo_gain_set_selector #(.DELAY_TICK_CYCLES(10))
    u_servo_gain_set_selector (
    .REF_CLK(clk), .RESET(rst), .RESTART(rs), .FEEDBACK_SOURCE_SELECT(fb),
    .GAIN_SWITCH_MODE(mode), .ENCODER_POSITION(pos), .ENCODER_VALID(vld),
    .ENCODER_SPEED_FILTER_TIME(ftim), .OBSERVER_GAIN(ogain),
    .GAIN_SELECT_IN(gsel), .POSITIONING_DONE(done), .TORQUE_REF(mag),
    .DEVIATION(mag), .ACCELERATION(mag), .SPEED_REF(mag), .POSITION_REF(mag),
    .TORQUE_THRESHOLD(thr), .DEVIATION_THRESHOLD(thr),
    .ACCELERATION_THRESHOLD(thr), .SPEED_REFERENCE_THRESHOLD(thr),
    .POSITION_SWITCH_THRESHOLD(thr), .ACTUAL_SPEED_THRESHOLD(thr),
    .SWITCH_HYSTERESIS(hys), .SWITCH_DELAY_TIME(dly),
    .POSITION_GAIN_RAMP_TIME(ramp), .SPEED_GAIN_FIRST(g1[0]),
    .SPEED_GAIN_SECOND(g2[0]), .INTEGRAL_TIME_FIRST(g1[1]),
    .INTEGRAL_TIME_SECOND(g2[1]), .POSITION_GAIN_FIRST(g1[2]),
    .POSITION_GAIN_SECOND(g2[2]), .TORQUE_FILTER_TIME_FIRST(g1[3]),
    .TORQUE_FILTER_TIME_SECOND(g2[3]), .SPEED_FEEDBACK(fbk),
    .ENCODER_SPEED(enc), .OBSERVED_SPEED(obs), .SECOND_GROUP_ACTIVE(grp),
    .GAIN_RAMPING(rmp), .SPEED_GAIN(sg), .INTEGRAL_TIME(it),
    .POSITION_GAIN(pg), .TORQUE_FILTER_TIME(tf));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // expected group when every condition is either met or not met
  function automatic logic want(input logic [3:0] m, input logic on);
    return m == 4'h9 || (on && m != 4'h0 && m <= 4'hA);
  endfunction : want
  task automatic restart(input logic [3:0] m, input logic f);
    @(posedge clk);
    mode <= m;
    fb <= f;
    rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
  endtask : restart
  // all conditions met or not; magnitudes clear the hysteresis band
  task automatic cond(input logic on);
    @(posedge clk);
    gsel <= on;
    done <= on;
    vel <= on ? 16'h01F4 : 16'h0000;
    mag <= on ? 16'(103 + ($random(seed) & 511)) : 16'($random(seed) & 63);
  endtask : cond
  // bounded wait for the group, then a hold long enough for delay and ramp
  task automatic wait_grp(input logic e);
    for (int i = 0; i < 1500 && grp !== e; i++) @(posedge clk);
    // a wait that runs out is a failure and ends the run
    if (grp !== e) begin
      fail_count++;
      end_sim();
    end
    repeat (80) @(posedge clk);
    #1;
    check(16'(grp), 16'(e));
    check(16'(rmp), 16'h0000);
    check(sg, e ? g2[0] : g1[0]);
    check(it, e ? g2[1] : g1[1]);
    check(pg, e ? g2[2] : g1[2]);
    check(tf, e ? g2[3] : g1[3]);
  endtask : wait_grp
  task automatic end_sim;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial begin
    for (int i = 0; i < 4; i++) begin
      g1[i] = 16'($random(seed));
      g2[i] = 16'($random(seed));
    end
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wait_grp(1'b0);
    for (int m = 0; m < 12; m++) begin
      cond(1'b0);
      restart(4'(m), 1'b0);
      wait_grp(want(4'(m), 1'b0));
      cond(1'b1);
      repeat (5) @(posedge clk);
      #1;
      check(16'(grp), 16'(want(4'(m), 1'b0)));
      wait_grp(want(4'(m), 1'b1));
    end
    @(posedge clk);
    mode <= 4'h9;
    wait_grp(1'b0);
    restart(4'h2, 1'b0);
    wait_grp(1'b1);
    @(posedge clk);
    mag <= 16'sh0064;
    wait_grp(1'b1);
    cond(1'b0);
    restart(4'h8, 1'b0);
    @(posedge clk);
    mag <= 16'sh0066;
    vel <= 16'h01F4;
    repeat (1200) @(posedge clk);
    wait_grp(1'b0);
    @(posedge clk);
    mag <= 16'sh0067;
    wait_grp(1'b1);
    @(posedge clk);
    ogain <= 16'h0000;
    vel <= 16'h0000;
    restart(4'h0, 1'b1);
    repeat (1200) @(posedge clk);
    #1;
    check(fbk, 16'h01F4);
    check(obs, 16'h01F4);
    restart(4'h0, 1'b0);
    repeat (1200) @(posedge clk);
    #1;
    check(fbk, 16'h0000);
    check(enc, 16'h0000);
    end_sim();
  end
endmodule : servo_gain_set_selector_tb
`default_nettype wire
